/* File: ais_pkg.sv */
package ais_pkg;
  localparam int CLK_MHZ           = 100;
  localparam int CONV14_US         = 43;
  localparam int CONV11_FASTER_US  = 8;
  localparam int CONV8_FASTER_US   = 15;
  localparam int RELAY_HOLD_US     = 800;
  localparam logic [4:0] AREA_BASIC = 5'h0A;
  localparam logic [4:0] AREA_EXP   = 5'h10;
  localparam logic [7:0] OFS_CMD    = 8'h00;
  localparam logic [7:0] OFS_SENSE  = 8'h04;
  localparam logic [7:0] OFS_RESULT = 8'h08;
  localparam logic [7:0] OFS_LIMIT  = 8'h0C;
  localparam logic [7:0] OFS_STATE  = 8'h10;
  localparam int IND_TBL  = 0;
  localparam int IND_SSCC = 1;
  localparam int IND_RLCC = 2;
  localparam int IND_SPV  = 3;
  localparam int IND_CPAR = 4;
  localparam int IND_DPAR = 5;
  localparam int IND_OVL  = 6;
  localparam int IND_OVC  = 7;
  localparam int IND_HI   = 8;
  localparam int IND_LO   = 9;
  localparam int IND_W    = 10;
  localparam int ST_BUSY  = 0;
  localparam int ST_RLBSY = 1;
  localparam int ST_CONV  = 2;
  localparam int ST_REJ   = 3;
  localparam int ST_HALT  = 4;
  localparam int ST_UNIT  = 5;
  localparam logic [IND_W-1:0] IND_RESET = 10'h000;
  localparam logic [15:0] LIMIT_HI_RESET = 16'h7FFF;
  localparam logic [15:0] LIMIT_LO_RESET = 16'h8000;

  typedef enum logic [2:0] {
    FN_SENSE = 3'b000,
    FN_WRITE = 3'b001,
    FN_READ  = 3'b010,
    FN_INIT  = 3'b011,
    FN_CTRL  = 3'b100
  } ais_func_type;

  typedef enum logic [1:0] {
    CV_IDLE = 2'b00,
    CV_RUN  = 2'b01,
    CV_CMP  = 2'b10
  } ais_conv_type;

  typedef struct packed {
    logic         rst_ind;
    logic         overlap;
    logic         solid;
    logic         seq;
    logic         cmp_en;
    logic         hi_res;
    logic         lo_res;
    logic         cmp_sel;
    ais_func_type func;
    logic [4:0]   area;
  } ais_cmd_type;

  typedef struct packed {
    logic       tbl_end;
    logic [1:0] scan_ctl;
    logic       point_req;
    logic       mux_address_reg_busy;
    logic       sp_viol;
    logic       ctl_par;
    logic       data_par;
    logic       overload;
  } ais_evt_type;
endpackage

/* File: ais_top.sv */
// The implementer's own choices: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module ais_top #(
  parameter int CONV14_CYC = ais_pkg::CONV14_US * ais_pkg::CLK_MHZ,
  parameter int CONV11_CYC = (ais_pkg::CONV14_US - ais_pkg::CONV11_FASTER_US) * ais_pkg::CLK_MHZ,
  parameter int CONV8_CYC  = (ais_pkg::CONV14_US - ais_pkg::CONV8_FASTER_US) * ais_pkg::CLK_MHZ,
  parameter int RELAY_CYC  = ais_pkg::RELAY_HOLD_US * ais_pkg::CLK_MHZ
) (
  // Clock and reset
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  // Wishbone slave
  input  wire logic                cyc_i,
  input  wire logic                stb_i,
  input  wire logic                we_i,
  input  wire logic [7:0]          adr_i,
  input  wire logic [3:0]          sel_i,
  input  wire logic [31:0]         dat_i,
  output logic      [31:0]         dat_o,
  output logic                     ack_o,
  // Channel and converter side
  input  wire ais_pkg::ais_evt_type evt_i,
  input  wire logic [15:0]         conv_data_i,
  output logic                     conv_valid_o,
  output logic      [15:0]         conv_data_o,
  // Status and interrupt requests, index 0 basic, 1 expander
  output logic      [1:0]          irq_ai_o,
  output logic      [1:0]          irq_cmp_o,
  output logic                     busy_o,
  output logic                     relay_busy_o
);
  import ais_pkg::*;

  if (CONV8_CYC < 1 || CONV11_CYC < CONV8_CYC || CONV14_CYC < CONV11_CYC
      || CONV14_CYC >= 65536) begin : g_bad_conv
    $error("conversion counts out of range");
  end
  if (RELAY_CYC < 1 || RELAY_CYC >= 1048576) begin : g_bad_relay
    $error("relay hold count out of range");
  end

  ais_cmd_type          cmd_q;
  ais_conv_type         cv_state;
  logic [IND_W-1:0]     ind [2];
  logic [IND_W-1:0]     set_vec;
  logic [IND_W-1:0]     clr_vec;
  logic [15:0]          sense_q;
  logic [15:0]          result_q;
  logic [15:0]          lim_hi;
  logic [15:0]          lim_lo;
  logic [15:0]          conv_cnt;
  logic [19:0]          hold_cnt;
  logic                 hold_run;
  logic                 unit_q;
  logic                 busy_q;
  logic                 dc_mode;
  logic                 overlap_q;
  logic                 relay_busy;
  logic                 relay_pend;
  logic                 ss_pend;
  logic                 dc_pend;
  logic                 cur_relay;
  logic                 cur_dc;
  logic                 cur_cmp;
  logic                 reject_q;
  logic                 halted;
  logic                 conv_done;
  logic                 halt_evt;
  logic                 wb_req;
  logic                 cmd_wr;
  logic                 area_hit;
  logic                 cmd_unit;
  logic                 accept;
  logic                 blast;
  logic                 do_sense;
  logic                 relay_addr;
  logic                 ss_addr;
  logic                 init_op;
  logic                 conflict;
  logic                 start_any;
  logic                 gen_busy;
  logic                 tbl_final;
  logic [15:0]          cyc_load;
  ais_cmd_type          new_cmd;
  logic [31:0]          rd_mux;

  // Bus: one wait cycle, writes take effect at the acknowledging edge
  assign wb_req = cyc_i & stb_i & ack_o;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= cyc_i & stb_i & ~ack_o;
      if (cyc_i & stb_i & ~ack_o) begin
        dat_o <= rd_mux;
      end
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (adr_i)
      OFS_CMD:    rd_mux = {16'h0000, cmd_q};
      OFS_SENSE:  rd_mux = {16'h0000, sense_q};
      OFS_RESULT: rd_mux = {16'h0000, result_q};
      OFS_LIMIT:  rd_mux = {lim_lo, lim_hi};
      OFS_STATE: begin
        rd_mux[ST_BUSY]  = gen_busy;
        rd_mux[ST_RLBSY] = relay_busy;
        rd_mux[ST_CONV]  = (cv_state != CV_IDLE);
        rd_mux[ST_REJ]   = reject_q;
        rd_mux[ST_HALT]  = halted;
        rd_mux[ST_UNIT]  = unit_q;
      end
      default:    rd_mux = 32'h0000_0000;
    endcase
  end

  // Command decode
  assign new_cmd  = ais_cmd_type'(dat_i[15:0]);
  assign cmd_wr   = wb_req & we_i & (adr_i == OFS_CMD) & (&sel_i[1:0]);
  assign area_hit = (new_cmd.area == AREA_BASIC) | (new_cmd.area == AREA_EXP);
  assign cmd_unit = (new_cmd.area == AREA_EXP);
  assign gen_busy = busy_q | evt_i.mux_address_reg_busy;

  always_comb begin
    accept = 1'b0;
    if (cmd_wr && area_hit) begin
      case (new_cmd.func)
        FN_SENSE, FN_CTRL: accept = 1'b1;
        FN_WRITE: begin
          // A relay point may join a running channel scan in overlap mode
          if (!new_cmd.solid && dc_mode && overlap_q) begin
            accept = ~halted;
          end else begin
            accept = ~gen_busy & ~halted;
          end
        end
        FN_READ, FN_INIT: accept = ~gen_busy & ~halted;
        default: accept = 1'b0;
      endcase
    end
  end

  assign blast      = accept && (new_cmd.func == FN_CTRL);
  assign do_sense   = accept && (new_cmd.func == FN_SENSE);
  assign ss_addr    = accept && (new_cmd.func == FN_WRITE) && new_cmd.solid;
  assign relay_addr = accept && (((new_cmd.func == FN_WRITE) && !new_cmd.solid)
                      || ((new_cmd.func == FN_READ) && new_cmd.seq));
  assign init_op    = accept && (new_cmd.func == FN_INIT);
  assign conflict   = relay_addr && dc_mode && overlap_q
                      && (relay_pend || (cv_state != CV_IDLE && cur_relay));
  assign halt_evt   = evt_i.sp_viol | evt_i.ctl_par;
  assign tbl_final  = evt_i.tbl_end & ~evt_i.scan_ctl[1];
  assign conv_done  = (cv_state == CV_RUN) && (conv_cnt == 16'h0001);
  assign start_any  = (cv_state == CV_IDLE) && !halted && (relay_pend || ss_pend || dc_pend);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_q    <= ais_cmd_type'(16'h0000);
      unit_q   <= 1'b0;
      reject_q <= 1'b0;
    end else if (cmd_wr) begin
      reject_q <= ~accept;
      if (accept) begin
        cmd_q <= new_cmd;
        if (!do_sense && !blast) begin
          unit_q <= cmd_unit;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lim_hi <= LIMIT_HI_RESET;
      lim_lo <= LIMIT_LO_RESET;
    end else if (wb_req && we_i && adr_i == OFS_LIMIT) begin
      if (sel_i[0]) lim_hi[7:0]  <= dat_i[7:0];
      if (sel_i[1]) lim_hi[15:8] <= dat_i[15:8];
      if (sel_i[2]) lim_lo[7:0]  <= dat_i[23:16];
      if (sel_i[3]) lim_lo[15:8] <= dat_i[31:24];
    end
  end

  // Operation state; blast abandons everything in flight, halt all but the relay busy hold
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_q     <= 1'b0;
      dc_mode    <= 1'b0;
      overlap_q  <= 1'b0;
      halted     <= 1'b0;
      relay_pend <= 1'b0;
      ss_pend    <= 1'b0;
      dc_pend    <= 1'b0;
    end else if (blast) begin
      busy_q     <= 1'b0;
      dc_mode    <= 1'b0;
      overlap_q  <= 1'b0;
      halted     <= 1'b0;
      relay_pend <= 1'b0;
      ss_pend    <= 1'b0;
      dc_pend    <= 1'b0;
    end else if (halt_evt) begin
      halted     <= 1'b1;
      busy_q     <= 1'b0;
      dc_mode    <= 1'b0;
      relay_pend <= 1'b0;
      ss_pend    <= 1'b0;
      dc_pend    <= 1'b0;
    end else begin
      if (ss_addr || init_op) begin
        busy_q <= 1'b1;
      end else if ((dc_mode && tbl_final)
                   || (conv_done && !cur_dc && !cur_relay)) begin
        busy_q <= 1'b0;
      end
      if (init_op) begin
        dc_mode   <= 1'b1;
        overlap_q <= new_cmd.overlap;
      end else if (tbl_final) begin
        dc_mode <= 1'b0;
      end
      // Pending requests are served relay first, then programmed, then channel
      if (relay_addr && !conflict) begin
        relay_pend <= 1'b1;
      end else if (start_any) begin
        relay_pend <= 1'b0;
      end
      if (ss_addr) begin
        ss_pend <= 1'b1;
      end else if (start_any && !relay_pend) begin
        ss_pend <= 1'b0;
      end
      if (dc_mode && evt_i.point_req) begin
        dc_pend <= 1'b1;
      end else if (start_any && !relay_pend && !ss_pend) begin
        dc_pend <= 1'b0;
      end
    end
  end

  // Converter timing by resolution; comparator takes one extra cycle
  always_comb begin
    if (cmd_q.lo_res) begin
      cyc_load = CONV8_CYC[15:0];
    end else if (cmd_q.hi_res) begin
      cyc_load = CONV14_CYC[15:0];
    end else begin
      cyc_load = CONV11_CYC[15:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || blast || halt_evt) begin
      cv_state  <= CV_IDLE;
      conv_cnt  <= 16'h0000;
      cur_relay <= 1'b0;
      cur_dc    <= 1'b0;
      cur_cmp   <= 1'b0;
      result_q  <= 16'h0000;
    end else begin
      case (cv_state)
        CV_IDLE: begin
          if (start_any) begin
            cv_state  <= CV_RUN;
            conv_cnt  <= cyc_load;
            cur_relay <= relay_pend;
            cur_dc    <= ~relay_pend & ~ss_pend;
            cur_cmp   <= cmd_q.cmp_en;
          end
        end
        CV_RUN: begin
          conv_cnt <= conv_cnt - 16'h0001;
          if (conv_done) begin
            result_q <= conv_data_i;
            cv_state <= cur_cmp ? CV_CMP : CV_IDLE;
          end
        end
        CV_CMP: cv_state <= CV_IDLE;
        default: cv_state <= CV_IDLE;
      endcase
    end
  end

  // Channel results leave as a one-cycle strobe for cycle stealing
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      conv_valid_o <= 1'b0;
      conv_data_o  <= 16'h0000;
    end else begin
      conv_valid_o <= conv_done & cur_dc & ~blast & ~halt_evt;
      if (conv_done && cur_dc) begin
        conv_data_o <= conv_data_i;
      end
    end
  end

  // Relay busy holds across back-to-back relay points
  always_ff @(posedge clk_i) begin
    if (rst_i || blast) begin
      relay_busy <= 1'b0;
      hold_run   <= 1'b0;
      hold_cnt   <= 20'h00000;
    end else begin
      if (relay_addr && !conflict) begin
        relay_busy <= 1'b1;
        hold_run   <= 1'b0;
      end else if (conv_done && cur_relay) begin
        hold_run <= 1'b1;
        hold_cnt <= RELAY_CYC[19:0];
      end else if (hold_run) begin
        hold_cnt <= hold_cnt - 20'h00001;
        if (hold_cnt == 20'h00001) begin
          hold_run   <= 1'b0;
          relay_busy <= 1'b0;
        end
      end
    end
  end

  // Indicator events for the unit of the last operation
  always_comb begin
    set_vec           = IND_RESET;
    set_vec[IND_TBL]  = dc_mode & evt_i.tbl_end & ~evt_i.scan_ctl[0];
    set_vec[IND_SSCC] = conv_done & ~cur_dc & ~cur_relay;
    set_vec[IND_RLCC] = conv_done & cur_relay;
    set_vec[IND_SPV]  = evt_i.sp_viol;
    set_vec[IND_CPAR] = evt_i.ctl_par;
    set_vec[IND_DPAR] = evt_i.data_par;
    set_vec[IND_OVL]  = conv_done & evt_i.overload;
    set_vec[IND_OVC]  = conflict;
    set_vec[IND_HI]   = (cv_state == CV_CMP)
                        && ($signed(result_q) >= $signed(lim_hi));
    set_vec[IND_LO]   = (cv_state == CV_CMP)
                        && ($signed(result_q) < $signed(lim_lo));
  end

  always_comb begin
    clr_vec = IND_RESET;
    if (do_sense && new_cmd.rst_ind) begin
      if (new_cmd.cmp_sel) begin
        clr_vec[IND_HI] = 1'b1;
        clr_vec[IND_LO] = 1'b1;
      end else begin
        clr_vec[IND_OVC:IND_TBL] = {IND_SPV+5{1'b1}};
      end
    end
  end

  // Set wins over a same-cycle sense clear; blast clears the addressed unit
  for (genvar u = 0; u < 2; u++) begin : g_unit
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        ind[u] <= IND_RESET;
      end else if (blast && cmd_unit == 1'(u)) begin
        ind[u] <= IND_RESET;
      end else begin
        ind[u] <= (ind[u] & ~((cmd_unit == 1'(u)) ? clr_vec : IND_RESET))
                  | ((unit_q == 1'(u)) ? set_vec : IND_RESET);
      end
    end
    assign irq_ai_o[u]  = |ind[u][IND_OVC:IND_TBL];
    assign irq_cmp_o[u] = |ind[u][IND_LO:IND_HI];
  end

  // Sense word captured at command time, before its own clear lands
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sense_q <= 16'h0000;
    end else if (do_sense) begin
      sense_q <= 16'h0000;
      if (new_cmd.cmp_sel) begin
        sense_q[1:0] <= ind[cmd_unit][IND_LO:IND_HI];
      end else begin
        sense_q[7:0] <= ind[cmd_unit][IND_OVC:IND_TBL];
        sense_q[8]   <= gen_busy;
        sense_q[9]   <= relay_busy;
      end
    end
  end

  assign busy_o       = gen_busy;
  assign relay_busy_o = relay_busy;
endmodule
`default_nettype wire

/* File: ais_top_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module ais_top_chk #(
  parameter int RELAY_CYC = 50
) (
  // Clock and reset
  input wire logic                 clk_i,
  input wire logic                 rst_i,
  // Register bus
  input wire logic                 cyc_i,
  input wire logic                 stb_i,
  input wire logic                 we_i,
  input wire logic [7:0]           adr_i,
  input wire logic                 ack_o,
  // Device side
  input wire ais_pkg::ais_evt_type evt_i,
  input wire logic                 conv_valid_o,
  input wire logic [1:0]           irq_ai_o,
  input wire logic [1:0]           irq_cmp_o,
  input wire logic                 busy_o,
  input wire logic                 relay_busy_o
);
  import ais_pkg::*;
  logic       cmd_wr;
  logic [1:0] kill_q;
  int         hold_cnt;

  // Command writes land at the acknowledged edge
  assign cmd_wr = cyc_i && stb_i && we_i && ack_o && adr_i == OFS_CMD;

  // Only blast can end relay busy early, yet every command write and halt excuses the hold check
  always_ff @(posedge clk_i) begin
    if (rst_i) kill_q <= 2'b00;
    else kill_q <= {kill_q[0], cmd_wr || evt_i.sp_viol || evt_i.ctl_par};
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !relay_busy_o) hold_cnt <= 0;
    else if (hold_cnt < RELAY_CYC) hold_cnt <= hold_cnt + 1;
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_AI_CLEAR: assert property (|($past(irq_ai_o) & ~irq_ai_o) |->
    $past(cmd_wr) || $past(cmd_wr, 2)) else $error("converter request fell unasked");
  AST_CMP_CLEAR: assert property (|($past(irq_cmp_o) & ~irq_cmp_o) |->
    $past(cmd_wr) || $past(cmd_wr, 2)) else $error("comparator request fell unasked");
  AST_BUSY_RISE: assert property ($rose(busy_o) |->
    evt_i.mux_address_reg_busy || $past(cmd_wr) || $past(cmd_wr, 2)) else $error("busy rose unasked");
  AST_RELAY_RISE: assert property ($rose(relay_busy_o) |->
    $past(cmd_wr) || $past(cmd_wr, 2)) else $error("relay busy rose unasked");
  AST_RELAY_HOLD: assert property ($fell(relay_busy_o) && !cmd_wr && kill_q == 2'b00 |->
    hold_cnt == RELAY_CYC) else $error("relay busy dropped early");
  AST_HALT_IRQ: assert property (evt_i.sp_viol || evt_i.ctl_par |->
    ##[1:2] irq_ai_o != 2'b00) else $error("halt event without request");
  AST_HALT_IDLE: assert property (evt_i.sp_viol || evt_i.ctl_par |->
    ##2 (!busy_o || evt_i.mux_address_reg_busy)) else $error("activity kept after halt");
  AST_DPAR_IRQ: assert property (evt_i.data_par |-> ##[1:2] irq_ai_o != 2'b00)
    else $error("data parity without request");
  AST_CHAN_BUSY: assert property (conv_valid_o |-> busy_o)
    else $error("channel result while idle");
endmodule

bind ais_top ais_top_chk #(.RELAY_CYC(RELAY_CYC)) u_chk (.clk_i, .rst_i, .cyc_i, .stb_i,
  .we_i, .adr_i, .ack_o, .evt_i, .conv_valid_o, .irq_ai_o, .irq_cmp_o, .busy_o, .relay_busy_o);
`default_nettype wire

/* File: ais_chan_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ais_chan_model (
  // Clock
  input  wire logic                clk_i,
  // Channel and converter lines toward the block
  output var ais_pkg::ais_evt_type evt_o,
  output logic [15:0]              data_o
);
  import ais_pkg::*;
  logic [4:0] p    = 5'h00;
  logic [1:0] sc   = 2'b00;
  logic       mux_address_reg = 1'b0;
  logic       ovl  = 1'b0;

  initial data_o = 16'h0000;

  always_comb begin
    evt_o           = '0;
    evt_o.tbl_end   = p[0];
    evt_o.scan_ctl  = sc;
    evt_o.point_req = p[1];
    evt_o.mux_address_reg_busy = mux_address_reg;
    evt_o.sp_viol   = p[2];
    evt_o.ctl_par   = p[3];
    evt_o.data_par  = p[4];
    evt_o.overload  = ovl;
  end

  // Converter input level, range flag and address register occupancy
  task automatic set(input logic [15:0] v, input logic o, input logic a);
    data_o <= v;
    ovl <= o;
    mux_address_reg <= a;
  endtask

  // Scan control is only meaningful beside a table end, so it is scrambled afterwards
  task automatic pulse(input int k, input logic [1:0] s);
    p <= 5'(1 << k);
    sc <= s;
    @(posedge clk_i);
    p <= 5'h00;
    sc <= ~s;
    @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

/* File: analog_input_status_interrupts_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module analog_input_status_interrupts_tb;
  import ais_pkg::*;
  localparam int          C8    = 10;
  localparam int          C11   = 20;
  localparam int          C14   = 30;
  localparam int          RLY   = 50;
  localparam logic [15:0] F_RST = 16'h8000;
  localparam logic [15:0] F_SOL = 16'h2000;
  localparam logic [15:0] F_LO  = 16'h0200;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i;
  logic        ack_o, conv_valid_o, busy_o, relay_busy_o;
  logic [7:0]  adr_i;
  logic [3:0]  sel_i;
  logic [31:0] dat_i, dat_o, q;
  logic [15:0] conv_data_i, conv_data_o, d, hi, lo;
  logic [15:0] res [3] = '{16'h0200, 16'h0000, 16'h0400};
  logic [1:0]  irq_ai_o, irq_cmp_o;
  ais_evt_type evt_i;
  int          errors, comparisons, n;

  ais_top #(.CONV14_CYC(C14), .CONV11_CYC(C11), .CONV8_CYC(C8), .RELAY_CYC(RLY)) u_dut (
    .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .evt_i,
    .conv_data_i, .conv_valid_o, .conv_data_o, .irq_ai_o, .irq_cmp_o, .busy_o, .relay_busy_o);
  ais_chan_model u_far (.clk_i, .evt_o(evt_i), .data_o(conv_data_i));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic tally_and_finish();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // Classic single cycle, held until acknowledged
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v);
    int k;
    k = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= v;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'b1 && k < 20);
    if (ack_o !== 1'b1) begin
      chk(32'h0, 32'h1);
      tally_and_finish();
    end
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic cmd(input ais_func_type f, input logic [4:0] a, input logic [15:0] fl);
    wb(1'b1, OFS_CMD, {16'h0000, fl | {8'h00, f, a}});
  endtask

  task automatic sense(input logic [4:0] a, input logic [15:0] fl);
    cmd(FN_SENSE, a, fl);
    wb(1'b0, OFS_SENSE, 32'h0);
  endtask

  task automatic wait_sig(input int s);
    logic v;
    n = 0;
    v = 1'b0;
    while (v !== 1'b1 && n < 400) begin
      @(posedge clk_i);
      n++;
      case (s)
        0: v = irq_ai_o[0];
        1: v = irq_ai_o[1];
        2: v = ~relay_busy_o;
        3: v = conv_valid_o;
        default: v = ~busy_o;
      endcase
    end
    if (v !== 1'b1) begin
      chk(32'h0, 32'h1);
      tally_and_finish();
    end
  endtask

  function automatic int exp_cyc(int r);
    return r == 0 ? C8 : (r == 1 ? C11 : C14);
  endfunction

  function automatic logic [1:0] exp_cmp(logic [15:0] v, logic [15:0] h, logic [15:0] l);
    return {$signed(v) < $signed(l), $signed(v) >= $signed(h)};
  endfunction

  initial begin
    // Reset and all byte selects are high at start; the bus stays idle until the first task call
    {rst_i, cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {4'h8, 8'h00, 4'hF, 32'h0};
    errors = 0;
    comparisons = 0;
    void'($urandom(43257));
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk({irq_ai_o, irq_cmp_o, busy_o, relay_busy_o}, 32'h0);
    wb(1'b0, 8'hFC, 32'h0);
    chk(q, 32'h0);
    for (int r = 0; r < 3; r++) begin
      d = 16'($urandom);
      u_far.set(d, r == 2, 1'b0);
      cmd(FN_WRITE, AREA_BASIC, F_SOL | res[r]);
      chk(busy_o, 1'b1);
      wait_sig(0);
      chk(n >= exp_cyc(r) - 3 && n <= exp_cyc(r) + 2, 1'b1);
      chk(busy_o, 1'b0);
      wb(1'b0, OFS_RESULT, 32'h0);
      chk({irq_ai_o, q[15:0]}, {2'b01, d});
      sense(AREA_BASIC, F_RST);
      chk(q[9:0], {3'b000, r == 2, 6'h02});
      chk(irq_ai_o, 2'b00);
    end
    for (int i = 0; i < 6; i++) begin
      hi = 16'($urandom_range(16383, 256));
      lo = hi - 16'h00C8;
      d = i == 0 ? hi : i == 1 ? lo : i == 2 ? lo - 16'h0001 : 16'($urandom);
      u_far.set(d, 1'b0, 1'b0);
      wb(1'b1, OFS_LIMIT, {lo, hi});
      cmd(FN_WRITE, AREA_BASIC, F_SOL | 16'h0800);
      wait_sig(0);
      @(posedge clk_i);
      chk(irq_cmp_o, {1'b0, |exp_cmp(d, hi, lo)});
      sense(AREA_BASIC, F_RST | 16'h0100);
      chk(q[1:0], exp_cmp(d, hi, lo));
      sense(AREA_BASIC, F_RST);
      chk({irq_cmp_o, q[7:0]}, 10'h002);
    end
    // Overlap needs a running channel scan; the second relay point collides
    cmd(FN_INIT, AREA_BASIC, 16'h4000 | F_LO);
    cmd(FN_WRITE, AREA_BASIC, F_LO);
    chk(relay_busy_o, 1'b1);
    cmd(FN_WRITE, AREA_BASIC, 16'h4000 | F_LO);
    u_far.pulse(1, 2'b11);
    wait_sig(3);
    chk(relay_busy_o, 1'b1);
    u_far.pulse(0, 2'b00);
    wait_sig(4);
    sense(AREA_BASIC, F_RST);
    chk(q[9:0], 10'h285);
    wait_sig(2);
    chk(n > RLY - 2 * C8 - 16 && n <= RLY, 1'b1);
    cmd(FN_WRITE, AREA_EXP, F_SOL);
    wait_sig(1);
    chk(irq_ai_o, 2'b10);
    sense(AREA_EXP, F_RST);
    chk(q[7:0], 8'h02);
    cmd(FN_WRITE, 5'h0B, F_SOL);
    wb(1'b0, OFS_STATE, 32'h0);
    chk(q[3], 1'b1);
    cmd(FN_WRITE, AREA_BASIC, F_SOL | 16'h0400);
    cmd(FN_READ, AREA_BASIC, 16'h0000);
    wb(1'b0, OFS_STATE, 32'h0);
    chk(q[3:0], 4'hD);
    sense(AREA_BASIC, 16'h0000);
    chk(q[8], 1'b1);
    wait_sig(0);
    sense(AREA_BASIC, F_RST);
    chk(q[7:0], 8'h02);
    cmd(FN_INIT, AREA_BASIC, 16'h0000);
    chk(busy_o, 1'b1);
    d = 16'($urandom);
    u_far.set(d, 1'b0, 1'b0);
    u_far.pulse(1, 2'b11);
    wait_sig(3);
    chk({irq_ai_o, conv_data_o}, {2'b00, d});
    u_far.pulse(0, 2'b11);
    @(posedge clk_i);
    chk({irq_ai_o[0], busy_o}, 2'b01);
    u_far.pulse(0, 2'b00);
    @(posedge clk_i);
    chk({irq_ai_o[0], busy_o}, 2'b10);
    sense(AREA_BASIC, F_RST);
    chk(q[7:0], 8'h01);
    u_far.set(16'h0000, 1'b0, 1'b1);
    @(posedge clk_i);
    chk(busy_o, 1'b1);
    u_far.set(16'h0000, 1'b0, 1'b0);
    @(posedge clk_i);
    chk(busy_o, 1'b0);
    for (int k = 2; k < 5; k++) begin
      cmd(FN_INIT, AREA_BASIC, 16'h0000);
      u_far.pulse(k, 2'b00);
      @(posedge clk_i);
      wb(1'b0, OFS_STATE, 32'h0);
      chk({irq_ai_o[0], q[4], q[0]}, {1'b1, k < 4, k == 4});
      sense(AREA_BASIC, 16'h0000);
      chk(q[5:3], 3'b001 << (k - 2));
      cmd(FN_CTRL, AREA_BASIC, 16'h0000);
      wb(1'b0, OFS_STATE, 32'h0);
      chk({irq_ai_o, q[4], q[0]}, 4'h0);
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
